// ==== hw/sch_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sch_map.svh"
module sch_device import sch_pkg::*; #(
  parameter int MEM_DEPTH = 256,
  parameter int RETRIG_CYC = `SCH_RETRIG_NS / `SCH_SYS_NS
) (
  // system side
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // message queue and comms config
  input wire logic msg_pending,
  input wire logic retrig_en,
  // status
  output logic comms_err,
  output logic rsp_pending,
  // link
  sch_if.dev lnk
);
  localparam int HDR = `SCH_HDR_BYTES;
  localparam int RXN = HDR + `SCH_WR_MAX;
  localparam int TXN = HDR + `SCH_RD_MAX;
  localparam int GAP_CYC = `SCH_RETRIG_GAP_NS / `SCH_SYS_NS;
  // one counter times both the hold-off and the release gap
  localparam int RT_W = $clog2(((RETRIG_CYC > GAP_CYC) ? RETRIG_CYC : GAP_CYC) + 1);

  // link side, cleared by select release
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] byte_cnt;
    logic [6:0] rx_sh;
  } sch_lnk_t;
  // link side, survives the frame for the system side to read
  typedef struct packed {
    logic [RXN-1:0][7:0] rxb;
    logic [6:0] rxn;
    logic tg;
  } sch_hold_t;
  typedef struct packed {
    sch_dst_t st;
    logic [1:0] ss_sy;
    logic ss_q;
    logic [1:0] tg_sy;
    logic tg_seen;
    logic hold;
    logic [6:0] idx;
    logic [7:0] crc;
    logic [7:0] ro;
    logic [15:0] addr;
    logic [15:0] len;
    logic pend;
    logic cerr;
    logic gap;
    logic [RT_W-1:0] rt;
    logic chg;
    logic [TXN-1:0][7:0] rsp;
    logic [MEM_DEPTH-1:0][7:0] mem;
  } sch_dcore_t;

  sch_lnk_t lk;
  sch_lnk_t lk_nxt;
  sch_hold_t h;
  sch_dcore_t q;
  sch_dcore_t q_nxt;
  logic frm_rst_n;
  logic miso_r;
  logic [7:0] tx_byte;
  logic want;

  assign frm_rst_n = reset_n & ~lnk.ss_n;

  // sampling on rising edges, counts restart with every frame
  always_comb begin
    lk_nxt = lk;
    lk_nxt.rx_sh = {lk.rx_sh[5:0], lnk.mosi};
    lk_nxt.bit_cnt = lk.bit_cnt + 3'h1;
    if (lk.bit_cnt == 3'h7 && lk.byte_cnt != 7'h7f) begin
      lk_nxt.byte_cnt = lk.byte_cnt + 7'h01;
    end
  end

  always_ff @(posedge lnk.sck or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      lk <= '0;
    end else begin
      lk <= lk_nxt;
    end
  end

  // received bytes stay put once the clock stops, so the system side
  // reads them as static data after it has seen select go high
  always_ff @(posedge lnk.sck or negedge reset_n) begin
    if (!reset_n) begin
      h <= '0;
    end else begin
      if (lk.bit_cnt == 3'h0 && lk.byte_cnt == 7'h00) begin
        h.tg <= ~h.tg;
      end
      if (lk.bit_cnt == 3'h7) begin
        if (lk.byte_cnt < 7'(RXN)) begin
          h.rxb[lk.byte_cnt] <= {lk.rx_sh, lnk.mosi};
        end
        h.rxn <= lk_nxt.byte_cnt;
      end
    end
  end

  // response buffer is only rewritten while no frame runs
  assign tx_byte = (lk.byte_cnt < 7'(TXN)) ? q.rsp[lk.byte_cnt] : `SCH_FILL;

  always_ff @(negedge lnk.sck or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      miso_r <= 1'b1;
    end else begin
      miso_r <= tx_byte[3'h7 - lk.bit_cnt];
    end
  end

  assign want = (q.pend | msg_pending) & ~q.hold;

  always_comb begin
    q_nxt = q;
    q_nxt.cerr = 1'b0;
    q_nxt.ss_sy = {q.ss_sy[0], lnk.ss_n};
    q_nxt.ss_q = q.ss_sy[1];
    q_nxt.tg_sy = {q.tg_sy[0], h.tg};
    case (q.st)
      D_IDLE: begin
        if (q.ss_sy[1] && !q.ss_q) begin
          q_nxt.hold = 1'b0;
          if (q.tg_sy[1] != q.tg_seen) begin
            q_nxt.tg_seen = q.tg_sy[1];
            if (h.rxb[`SCH_B_OP] == `SCH_FILL) begin
              q_nxt.pend = 1'b0;
            end else if (h.rxn >= 7'(HDR)) begin
              q_nxt.hold = 1'b1;
              q_nxt.idx = '0;
              q_nxt.crc = `SCH_CRC_INIT;
              q_nxt.addr = {h.rxb[`SCH_B_AHI], h.rxb[`SCH_B_ALO]};
              q_nxt.len = {h.rxb[`SCH_B_LHI], h.rxb[`SCH_B_LLO]};
              q_nxt.st = D_CRC;
            end
          end
        end
      end
      D_CRC: begin
        q_nxt.crc = sch_crc8(q.crc, h.rxb[q.idx]);
        q_nxt.idx = q.idx + 7'h01;
        if (q.idx == 7'(`SCH_B_LHI)) begin
          q_nxt.st = D_DEC;
        end
      end
      D_DEC: begin
        q_nxt.idx = '0;
        q_nxt.st = D_RSP;
        if (q.crc != h.rxb[`SCH_B_CRC]) begin
          q_nxt.ro = `SCH_OP_BAD_CRC;
        end else begin
          case (h.rxb[`SCH_B_OP])
            `SCH_OP_WR_REQ: begin
              q_nxt.ro = `SCH_OP_WR_FAIL;
              if (q.len > 16'(`SCH_WR_MAX)) begin
                q_nxt.cerr = 1'b1;
              end else if ({9'h000, h.rxn} >= 16'(HDR) + q.len &&
                           {1'b0, q.addr} + {1'b0, q.len} <= 17'(MEM_DEPTH + 1)) begin
                q_nxt.ro = `SCH_OP_WR_OK;
                if (q.len > 16'h0001) begin
                  q_nxt.st = D_WR;
                end
              end
            end
            `SCH_OP_RD_REQ: begin
              q_nxt.ro = `SCH_OP_RD_FAIL;
              if (q.len <= 16'(`SCH_RD_MAX) &&
                  {1'b0, q.addr} + {1'b0, q.len} <= 17'(MEM_DEPTH)) begin
                q_nxt.ro = `SCH_OP_RD_OK;
                if (q.len != 16'h0000) begin
                  q_nxt.st = D_RD;
                end
              end
            end
            default: begin
              q_nxt.ro = `SCH_OP_BAD_REQ;
            end
          endcase
        end
      end
      D_WR: begin
        // trailing data crc is never checked at this level
        q_nxt.mem[q.addr + {9'h000, q.idx}] = h.rxb[7'(HDR) + q.idx];
        q_nxt.idx = q.idx + 7'h01;
        if ({9'h000, q.idx} + 16'h0002 >= q.len) begin
          q_nxt.st = D_RSP;
        end
      end
      D_RD: begin
        q_nxt.rsp[7'(HDR) + q.idx] = q.mem[q.addr + {9'h000, q.idx}];
        q_nxt.idx = q.idx + 7'h01;
        if ({9'h000, q.idx} + 16'h0001 >= q.len) begin
          q_nxt.st = D_RSP;
        end
      end
      D_RSP: begin
        q_nxt.rsp[`SCH_B_OP] = q.ro;
        q_nxt.rsp[`SCH_B_ALO] = q.addr[7:0];
        q_nxt.rsp[`SCH_B_AHI] = q.addr[15:8];
        q_nxt.rsp[`SCH_B_LLO] = q.len[7:0];
        q_nxt.rsp[`SCH_B_LHI] = q.len[15:8];
        q_nxt.rsp[`SCH_B_CRC] = sch_crc8(sch_crc8(sch_crc8(sch_crc8(sch_crc8(
          `SCH_CRC_INIT, q.ro), q.addr[7:0]), q.addr[15:8]), q.len[7:0]),
          q.len[15:8]);
        q_nxt.pend = 1'b1;
        q_nxt.hold = 1'b0;
        q_nxt.st = D_IDLE;
      end
      default: begin
        q_nxt.st = D_IDLE;
      end
    endcase
    if (!q.ss_sy[1]) begin
      q_nxt.hold = 1'b1;
    end
    // a notify held low too long is released briefly so a host
    // that missed the edge gets a fresh one
    if (want && !q.gap) begin
      q_nxt.rt = q.rt + RT_W'(1);
      if (retrig_en && q.rt == RT_W'(RETRIG_CYC - 1)) begin
        q_nxt.gap = 1'b1;
        q_nxt.rt = '0;
      end
    end else if (q.gap) begin
      q_nxt.rt = q.rt + RT_W'(1);
      if (q.rt == RT_W'(GAP_CYC - 1)) begin
        q_nxt.gap = 1'b0;
        q_nxt.rt = '0;
      end
    end else begin
      q_nxt.rt = '0;
    end
    // synced select drops notify at once, not a cycle after hold
    q_nxt.chg = want & ~q.gap & q.ss_sy[1];
  end

  // clock enable freezes the system side only; the link side
  // follows the serial clock, which runs at up to 8 MHz
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= q_nxt;
    end
  end

  assign lnk.miso = miso_r;
  assign lnk.chg_o = 1'b0;
  assign lnk.chg_oe = q.chg;
  assign comms_err = q.cerr;
  assign rsp_pending = q.pend;
endmodule : sch_device
`default_nettype wire

// ==== hw/sch_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sch_map.svh"
module sch_host import sch_pkg::*; #(
  parameter int RDN = 15,
  parameter int HALF_CYC = (`SCH_SCK_MIN_PER_PS / 2 + `SCH_SYS_PER_PS - 1) / `SCH_SYS_PER_PS,
  parameter int TMO_CYC = `SCH_RSP_TMO_NS / `SCH_SYS_NS
) (
  // system side
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_len,
  input wire logic [8*(`SCH_WR_MAX-1)-1:0] cmd_wdata,
  output logic cmd_ready,
  // response
  output logic rsp_valid,
  output logic rsp_tmo,
  output logic [7:0] rsp_op,
  output logic [15:0] rsp_len,
  output logic [8*RDN-1:0] rsp_data,
  output logic notify_evt,
  // link
  sch_if.host lnk
);
  localparam int HDR = `SCH_HDR_BYTES;
  localparam int TXN = HDR + `SCH_WR_MAX;
  localparam int RXN = HDR + RDN;
  localparam int DV_W = $clog2(HALF_CYC + 1);
  localparam int TM_W = $clog2(TMO_CYC + 1);

  typedef struct packed {
    sch_hst_t st;
    logic [1:0] ms_sy;
    logic [1:0] cg_sy;
    logic cg_q;
    logic fell;
    logic fetch;
    logic [DV_W-1:0] dv;
    logic [2:0] bit_cnt;
    logic [6:0] idx;
    logic [6:0] nb;
    logic [7:0] sh;
    logic [TXN-1:0][7:0] tx;
    logic [RXN-1:0][7:0] rx;
    logic sck;
    logic ss_n;
    logic mosi;
    logic rdy;
    logic rv;
    logic tmo;
    logic evt;
    logic [TM_W-1:0] tm;
  } sch_hcore_t;

  sch_hcore_t q;
  sch_hcore_t q_nxt;
  logic fall;
  logic tick;
  logic [15:0] ln;
  logic [7:0] c;
  logic [7:0] rbyte;

  assign fall = q.cg_q & ~q.cg_sy[1];
  assign tick = q.dv == DV_W'(HALF_CYC - 1);
  assign rbyte = {q.sh[6:0], q.ms_sy[1]};

  always_comb begin
    q_nxt = q;
    ln = '0;
    c = `SCH_CRC_INIT;
    q_nxt.rv = 1'b0;
    q_nxt.tmo = 1'b0;
    q_nxt.evt = 1'b0;
    q_nxt.ms_sy = {q.ms_sy[0], lnk.miso};
    q_nxt.cg_sy = {q.cg_sy[0], lnk.chg};
    q_nxt.cg_q = q.cg_sy[1];
    q_nxt.dv = tick ? '0 : q.dv + DV_W'(1);
    case (q.st)
      H_IDLE: begin
        q_nxt.evt = fall;
        if (cmd_valid) begin
          ln = cmd_write ? ((cmd_len == 16'h0000) ? 16'h0000 : cmd_len + 16'h0001) : cmd_len;
          q_nxt.tx[`SCH_B_OP] = cmd_write ? `SCH_OP_WR_REQ : `SCH_OP_RD_REQ;
          q_nxt.tx[`SCH_B_ALO] = cmd_addr[7:0];
          q_nxt.tx[`SCH_B_AHI] = cmd_addr[15:8];
          q_nxt.tx[`SCH_B_LLO] = ln[7:0];
          q_nxt.tx[`SCH_B_LHI] = ln[15:8];
          for (int i = 0; i < HDR - 1; i++) begin
            c = sch_crc8(c, q_nxt.tx[i]);
          end
          q_nxt.tx[`SCH_B_CRC] = c;
          c = `SCH_CRC_INIT;
          for (int i = 0; i < `SCH_WR_MAX - 1; i++) begin
            q_nxt.tx[HDR + i] = cmd_wdata[8*i +: 8];
            if (16'(i) < cmd_len) begin
              c = sch_crc8(c, cmd_wdata[8*i +: 8]);
            end
          end
          if (cmd_write && cmd_len != 16'h0000) begin
            q_nxt.tx[7'(HDR) + cmd_len[6:0]] = c;
          end
          q_nxt.nb = 7'(HDR) + ln[6:0];
          q_nxt.fetch = 1'b0;
          q_nxt.fell = 1'b0;
          q_nxt.rdy = 1'b0;
          q_nxt.idx = '0;
          q_nxt.bit_cnt = '0;
          q_nxt.dv = '0;
          q_nxt.ss_n = 1'b0;
          q_nxt.st = H_XFER;
        end
      end
      H_XFER: begin
        if (tick && q.sck) begin
          if (q.idx == q.nb) begin
            q_nxt.ss_n = 1'b1;
            q_nxt.st = H_GAP;
          end else begin
            q_nxt.sck = 1'b0;
            q_nxt.mosi = q.fetch ? 1'b1 : q.tx[q.idx][3'h7 - q.bit_cnt];
          end
        end else if (tick) begin
          q_nxt.sck = 1'b1;
          q_nxt.sh = rbyte;
          q_nxt.bit_cnt = q.bit_cnt + 3'h1;
          if (q.bit_cnt == 3'h7) begin
            q_nxt.idx = q.idx + 7'h01;
            // write frames leave miso unread
            if (q.fetch && q.idx < 7'(RXN)) begin
              q_nxt.rx[q.idx] = rbyte;
            end
            if (q.fetch && q.idx == 7'(`SCH_B_CRC) && q.rx[`SCH_B_OP] == `SCH_OP_RD_OK) begin
              q_nxt.nb = ({q.rx[`SCH_B_LHI], q.rx[`SCH_B_LLO]} > 16'(RDN)) ? 7'(RXN) :
                7'(HDR) + q.rx[`SCH_B_LLO][6:0];
            end
          end
        end
      end
      H_GAP: begin
        // select stays high a half period so the client sees it
        if (tick) begin
          q_nxt.tm = '0;
          q_nxt.st = q.fetch ? H_IDLE : H_WAIT;
          q_nxt.rv = q.fetch;
          q_nxt.rdy = q.fetch;
        end
      end
      H_WAIT: begin
        q_nxt.tm = q.tm + TM_W'(1);
        if (q.fell) begin
          q_nxt.fell = 1'b0;
          q_nxt.fetch = 1'b1;
          // last request bit may be low; fetch frames open with ones
          q_nxt.mosi = 1'b1;
          q_nxt.nb = 7'(HDR);
          q_nxt.idx = '0;
          q_nxt.bit_cnt = '0;
          q_nxt.dv = '0;
          q_nxt.ss_n = 1'b0;
          q_nxt.st = H_XFER;
        end else if (q.tm == TM_W'(TMO_CYC - 1)) begin
          q_nxt.tmo = 1'b1;
          q_nxt.rdy = 1'b1;
          q_nxt.st = H_IDLE;
        end
      end
      default: begin
        q_nxt.st = H_IDLE;
      end
    endcase
    if (fall) begin
      q_nxt.fell = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.sck <= 1'b1;
      q.ss_n <= 1'b1;
      q.mosi <= 1'b1;
      q.rdy <= 1'b1;
      q.ms_sy <= 2'h3;
      q.cg_sy <= 2'h3;
      q.cg_q <= 1'b1;
    end else if (clk_en) begin
      q <= q_nxt;
    end
  end

  assign lnk.sck = q.sck;
  assign lnk.ss_n = q.ss_n;
  assign lnk.mosi = q.mosi;
  assign cmd_ready = q.rdy;
  assign rsp_valid = q.rv;
  assign rsp_tmo = q.tmo;
  assign rsp_op = q.rx[`SCH_B_OP];
  assign rsp_len = {q.rx[`SCH_B_LHI], q.rx[`SCH_B_LLO]};
  assign rsp_data = q.rx[RXN-1:HDR];
  assign notify_evt = q.evt;
endmodule : sch_host
`default_nettype wire

// ==== inc/sch_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sch_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso;
  logic chg_o;
  logic chg_oe;
  logic chg;
  // pull-up on the open-drain notify line
  assign chg = chg_oe ? chg_o : 1'b1;
  modport dev(input sck, input ss_n, input mosi, output miso, output chg_o, output chg_oe);
  modport host(output sck, output ss_n, output mosi, input miso, input chg);
endinterface : sch_if
`default_nettype wire

// ==== inc/sch_map.svh ====
// Notes on behaviour
// - clock idles high; shift falling, sample rising
// - eight clocks per byte, both ways, MSB first
// - host holds select low for whole transaction
// - select release ends or aborts the transaction
// - client works with serial clock to 8 MHz
// - host sends all-ones bytes while reading
// - host ignores client data during writes
// - open-drain low notify: response or message waiting
// - host acts on notify falling edge only
// - host learns of messages from notify, no polling
// - retrigger option re-pulses a long-held notify
// - write opcodes: request, success, failure
// - read opcodes: request, success, failure
// - invalid request and invalid crc responses
// - notify must go active before response fetch
// - six-byte header: op, addr, len, crc
// - header crc8 over first five bytes
// - no integrity check on write payload
// - write over fifteen bytes: discard, report error
// - host waits for notify, times out at 10 ms
// - notify held off while select low, until processed
// - read length above 64 fails
`ifndef SCH_MAP_SVH
`define SCH_MAP_SVH
`define SCH_OP_WR_REQ 8'h01
`define SCH_OP_WR_OK 8'h81
`define SCH_OP_WR_FAIL 8'h41
`define SCH_OP_RD_REQ 8'h02
`define SCH_OP_RD_OK 8'h82
`define SCH_OP_RD_FAIL 8'h42
`define SCH_OP_BAD_REQ 8'h04
`define SCH_OP_BAD_CRC 8'h08
`define SCH_FILL 8'hff
`define SCH_CRC_POLY 8'h07
`define SCH_CRC_INIT 8'h00
`define SCH_HDR_BYTES 6
`define SCH_B_OP 0
`define SCH_B_ALO 1
`define SCH_B_AHI 2
`define SCH_B_LLO 3
`define SCH_B_LHI 4
`define SCH_B_CRC 5
`define SCH_WR_MAX 15
`define SCH_RD_MAX 64
`define SCH_SYS_PER_PS 10000
`define SCH_SCK_MIN_PER_PS 125000
`define SCH_SYS_NS 10
`define SCH_RSP_TMO_NS 10000000
`define SCH_RETRIG_NS 1000000
`define SCH_RETRIG_GAP_NS 1000
`endif

// ==== inc/sch_pkg.sv ====
`default_nettype none
`include "sch_map.svh"
package sch_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_CRC = 3'b001,
    D_DEC = 3'b010,
    D_WR = 3'b011,
    D_RD = 3'b100,
    D_RSP = 3'b101
  } sch_dst_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_XFER = 2'b01,
    H_GAP = 2'b10,
    H_WAIT = 2'b11
  } sch_hst_t;
  function automatic logic [7:0] sch_crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `SCH_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : sch_crc8
endpackage : sch_pkg
`default_nettype wire

// ==== testbench/sch_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sch_link_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // link
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic chg_o,
  input wire logic chg_oe,
  input wire logic chg
);
  logic ss_q;
  logic fetch_r;
  logic seen_r;
  // frames alternate request, fetch; holds only while no timeout is taken
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ss_q <= 1'b1;
      fetch_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      ss_q <= ss_n;
      if (ss_n && !ss_q) fetch_r <= !fetch_r;
      if (!ss_n) seen_r <= 1'b0;
      else if (!chg) seen_r <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_sck_idle_high: assert property (ss_n |-> sck)
    else $error("serial clock not high while deselected");
  a_mosi_on_fall: assert property (!ss_n && $stable(ss_n) && $changed(mosi) |-> $fell(sck))
    else $error("host data moved off a falling clock");
  a_miso_on_fall: assert property (!ss_n && $stable(ss_n) && $changed(miso) |-> $fell(sck))
    else $error("client data moved off a falling clock");
  a_sck_low_phase: assert property ($fell(sck) |-> !sck [*6])
    else $error("serial clock low phase too short");
  a_sck_high_phase: assert property ($rose(sck) |-> sck [*6])
    else $error("serial clock high phase too short");
  a_notify_drive_low: assert property (chg_oe |-> !chg_o && !chg)
    else $error("notify enabled but line not low");
  a_notify_held_off: assert property (!ss_n [*4] |-> !chg_oe)
    else $error("notify asserted while selected");
  a_fetch_after_edge: assert property ($fell(ss_n) && fetch_r |-> seen_r)
    else $error("fetch started before notify fell");
  a_answer_bound: assert property ($rose(ss_n) && !fetch_r |-> ##[1:120] chg_oe)
    else $error("no notify after a request");
  a_fill_on_fetch: assert property (!ss_n && fetch_r |-> mosi)
    else $error("host data not all ones in a fetch");
endmodule : sch_link_sva
`default_nettype wire

// ==== testbench/spi_client_header_protocol_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_client_header_protocol_test import sch_pkg::*;;
  logic sys_clk, reset_n, run_en, msg_pending, retrig_en, cmd_valid, cmd_write;
  logic [15:0] cmd_addr, cmd_len, lfsr_s;
  logic [111:0] cmd_wdata;
  logic cmd_ready, rsp_valid, rsp_tmo, notify_evt, err_a, err_b, pend_a, pend_b;
  logic [7:0] rsp_op, r;
  logic [15:0] rsp_len;
  logic [119:0] rsp_data;
  logic [7:0] mem [256];
  logic known [256];
  int bad_count, checked, evt_count, err_a_cnt, err_b_cnt, tmo_cnt, n;
  sch_if lnk_a ();
  sch_if lnk_b ();
  sch_host #(.TMO_CYC(2000)) sch_host_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(run_en), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_tmo(rsp_tmo), .rsp_op(rsp_op), .rsp_len(rsp_len), .rsp_data(rsp_data),
    .notify_evt(notify_evt), .lnk(lnk_a));
  sch_device #(.RETRIG_CYC(50)) sch_device_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(run_en), .msg_pending(msg_pending), .retrig_en(retrig_en), .comms_err(err_a),
    .rsp_pending(pend_a), .lnk(lnk_a));
  // second device faces the bench, which breaks host rules on purpose
  sch_device #(.RETRIG_CYC(50)) sch_device_inst_b (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(run_en), .msg_pending(msg_pending), .retrig_en(retrig_en), .comms_err(err_b),
    .rsp_pending(pend_b), .lnk(lnk_b));
  sch_link_sva sch_link_sva_inst (.sys_clk(sys_clk), .reset_n(reset_n), .sck(lnk_a.sck),
    .ss_n(lnk_a.ss_n), .mosi(lnk_a.mosi), .miso(lnk_a.miso), .chg_o(lnk_a.chg_o),
    .chg_oe(lnk_a.chg_oe), .chg(lnk_a.chg));
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    if (notify_evt === 1'b1) evt_count++;
    if (err_a === 1'b1) err_a_cnt++;
    if (err_b === 1'b1) err_b_cnt++;
    if (rsp_tmo === 1'b1) tmo_cnt++;
  end
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step
  function automatic logic [7:0] crc_b(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction : crc_b
  // length field of a write counts the appended data crc
  function automatic logic [15:0] wlen(input logic [15:0] l);
    return (l == 16'h0000) ? 16'h0000 : l + 16'h0001;
  endfunction : wlen
  function automatic logic [7:0] exp_op(input logic w, input logic [15:0] a, input logic [15:0] l);
    if (w) return (int'(a) + int'(wlen(l)) <= 257) ? 8'h81 : 8'h41;
    return (l <= 16'h0040 && int'(a) + int'(l) <= 256) ? 8'h82 : 8'h42;
  endfunction : exp_op
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic host_cmd(input logic w, input logic [15:0] a, input logic [15:0] l);
    logic [111:0] wd;
    int k;
    for (k = 0; k < 14; k++) begin
      lfsr_s = lfsr_step(lfsr_s);
      wd[8*k +: 8] = lfsr_s[7:0];
    end
    k = 0;
    while (cmd_ready !== 1'b1 && k < 1000) begin
      @(negedge sys_clk);
      k++;
    end
    chk(cmd_ready, 1'b1);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_len <= l;
    cmd_wdata <= wd;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20000) begin
      @(negedge sys_clk);
      k++;
    end
    chk(rsp_valid, 1'b1);
    chk(rsp_op, exp_op(w, a, l));
    chk(rsp_len, w ? wlen(l) : l);
    chk(pend_a, 1'b0);
    if (w && exp_op(w, a, l) == 8'h81) begin
      for (k = 0; k < l; k++) begin
        mem[int'(a) + k] = wd[8*k +: 8];
        known[int'(a) + k] = 1'b1;
      end
    end
    if (!w && exp_op(w, a, l) == 8'h82) begin
      for (k = 0; k < l && k < 15; k++) begin
        if (known[int'(a) + k]) chk(rsp_data[8*k +: 8], mem[int'(a) + k]);
      end
    end
  endtask : host_cmd
  // bench-made link clock, mode 3, msb first
  task automatic xfer_b(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      lnk_b.sck = 1'b0;
      lnk_b.mosi = tx[i];
      #24;
      lnk_b.sck = 1'b1;
      rx[i] = lnk_b.miso;
      #24;
    end
    lnk_b.mosi = ~tx[0];
  endtask : xfer_b
  task automatic b_frame(input logic [7:0] op, input logic [15:0] l, input logic [7:0] flip,
                         input int nd, output logic [7:0] rop);
    logic [7:0] c;
    logic [7:0] rx;
    int k;
    c = crc_b(crc_b(crc_b(crc_b(crc_b(8'h00, op), 8'h00), 8'h00), l[7:0]), l[15:8]) ^ flip;
    lnk_b.ss_n = 1'b0;
    #24;
    xfer_b(op, rx);
    xfer_b(8'h00, rx);
    xfer_b(8'h00, rx);
    xfer_b(l[7:0], rx);
    xfer_b(l[15:8], rx);
    xfer_b(c, rx);
    repeat (nd) xfer_b(8'h5a, rx);
    #24;
    lnk_b.ss_n = 1'b1;
    k = 0;
    while (lnk_b.chg !== 1'b0 && k < 1000) begin
      @(negedge sys_clk);
      k++;
    end
    chk(lnk_b.chg, 1'b0);
    chk(pend_b, 1'b1);
    lnk_b.ss_n = 1'b0;
    #24;
    xfer_b(8'hff, rop);
    repeat (5) xfer_b(8'hff, rx);
    #24;
    lnk_b.ss_n = 1'b1;
    #300;
    chk(pend_b, 1'b0);
  endtask : b_frame
  initial begin
    #900_000;
    bad_count++;
    complete_run;
  end
  initial begin
    {reset_n, msg_pending, retrig_en, cmd_valid, cmd_write} = 5'h00;
    {run_en, cmd_addr, cmd_len, cmd_wdata} = {1'b1, 144'h0};
    {lnk_b.sck, lnk_b.ss_n, lnk_b.mosi} = 3'h7;
    {bad_count, checked, evt_count, err_a_cnt, err_b_cnt, tmo_cnt} = '0;
    lfsr_s = 16'h0008;
    for (int i = 0; i < 256; i++) known[i] = 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    b_frame(8'h01, 16'h0010, 8'h00, 16, r);
    chk(r, 8'h41);
    chk(err_b_cnt, 1);
    b_frame(8'h02, 16'h0004, 8'h01, 0, r);
    chk(r, 8'h08);
    b_frame(8'h03, 16'h0004, 8'h00, 0, r);
    chk(r, 8'h04);
    // short frame then release: must leave the notify line alone
    lnk_b.ss_n = 1'b0;
    #24;
    repeat (3) xfer_b(8'h02, r);
    lnk_b.ss_n = 1'b1;
    n = 0;
    repeat (200) begin
      @(negedge sys_clk);
      if (lnk_b.chg === 1'b0) n++;
    end
    chk(n, 0);
    b_frame(8'h01, 16'h0003, 8'h00, 3, r);
    chk(r, 8'h81);
    host_cmd(1'b1, 16'h0000, 16'h0000);
    host_cmd(1'b1, 16'h0010, 16'h000e);
    host_cmd(1'b0, 16'h0010, 16'h000f);
    host_cmd(1'b1, 16'h00f2, 16'h000e);
    host_cmd(1'b1, 16'h00fa, 16'h000e);
    host_cmd(1'b0, 16'h00c0, 16'h0040);
    host_cmd(1'b0, 16'h0000, 16'h0041);
    repeat (8) begin
      lfsr_s = lfsr_step(lfsr_s);
      host_cmd(lfsr_s[0], lfsr_s[15] ? {8'h00, lfsr_s[12:5]} : lfsr_s,
               lfsr_s[0] ? 16'(lfsr_s[4:1] % 15) : 16'(lfsr_s[5:1] % 20));
    end
    evt_count = 0;
    @(posedge sys_clk);
    msg_pending <= 1'b1;
    repeat (400) @(posedge sys_clk);
    chk(evt_count, 1);
    evt_count = 0;
    retrig_en <= 1'b1;
    repeat (400) @(posedge sys_clk);
    chk(evt_count >= 2, 1);
    msg_pending <= 1'b0;
    chk(err_a_cnt, 0);
    chk(tmo_cnt, 0);
    complete_run;
  end
endmodule : spi_client_header_protocol_test
`default_nettype wire
